// ---- sbc_pkg.sv ----
// Shared constants, register map and state type of the serial baud clock select block.
package sbc_pkg;

   // ==========================================================================
   // Clock rates and derived divide counts
   // ==========================================================================
   localparam int  CLK_HZ        = 40_000_000;   // Board clock of this block.
   localparam int  CLK_KHZ       = CLK_HZ / 1000;
   localparam int  TRIG_HZ       = 2_000_000;    // Timer trigger rate.
   localparam int  MASTER_HZ     = 4_000_000;    // Timer master clock rate.
   localparam real HS_CLK_KHZ    = 615.385;      // Fixed high-speed port A clock.
   localparam int  TRIG_DIV      = CLK_HZ / TRIG_HZ;
   localparam int  MASTER_DIV    = CLK_HZ / MASTER_HZ;
   localparam int  HS_DIV        = int'(real'(CLK_KHZ) / HS_CLK_KHZ);
   localparam int  PRESCALE_LO   = 16;
   localparam int  PRESCALE_HI   = 256;
   localparam int  NUM_TIMERS    = 2;

   // ==========================================================================
   // Register byte offsets
   // ==========================================================================
   localparam logic [7:0] OFS_T0_CTRL    = 8'h00;
   localparam logic [7:0] OFS_T0_CONST   = 8'h04;
   localparam logic [7:0] OFS_T1_CTRL    = 8'h08;
   localparam logic [7:0] OFS_T1_CONST   = 8'h0C;
   localparam logic [7:0] OFS_LINE_CTRL  = 8'h10;
   localparam logic [7:0] OFS_LINE_STAT  = 8'h14;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int CW_CTRL_BIT    = 0;   // Set in a control word.
   localparam int CW_RESET_BIT   = 1;   // Software reset of the channel.
   localparam int CW_PRE_BIT     = 5;   // Prescale 256 when set, else 16.
   localparam int CW_MODE_BIT    = 6;   // Counter mode when set, else timer.
   localparam int CW_RUN_BIT     = 7;   // Read only: channel running.
   localparam int LC_SPEED_BIT   = 0;   // Port A speed select, 1 = low speed.
   localparam int LC_SNAP_BIT    = 1;   // Write 1: latch external status into the status register.
   localparam int LS_RING_BIT    = 0;
   localparam int LS_CARRIER_BIT = 1;
   localparam int LS_LOWSEL_BIT  = 2;
   localparam int LS_RUN0_BIT    = 3;
   localparam int LS_RUN1_BIT    = 4;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic SPEED_REQ_RST = 1'b0;   // High-speed path after reset.

   // ==========================================================================
   // State of the top module
   // ==========================================================================
   typedef struct packed {
      logic [1:0]                  sync_busy;
      logic [1:0]                  sync_ready;
      logic [NUM_TIMERS-1:0]       run;
      logic [NUM_TIMERS-1:0]       counter_mode;
      logic [NUM_TIMERS-1:0]       pre256;
      logic [NUM_TIMERS-1:0][7:0]  tc;
      logic [NUM_TIMERS-1:0][7:0]  cnt;
      logic [NUM_TIMERS-1:0][7:0]  pre;
      logic [NUM_TIMERS-1:0]       zc;
      logic                        speed_req;
      logic                        sel_low;
      logic                        port_a_clk;
      logic                        ring_snap;
      logic                        carrier_snap;
      logic                        ack;
      logic [31:0]                 rdata;
   } sbc_state_t;

endpackage : sbc_pkg

// ---- sbc_clk_div.sv ----
// Integer clock divider giving a one-cycle tick and a square wave.
`timescale 1ns/1ps
`default_nettype none

module sbc_clk_div
   import sbc_pkg::*;
#(
   parameter int DIV = 20
) (
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Divided outputs.
   output logic      tick_o,
   output logic      clk_o
);

   localparam int W = $clog2(DIV);

   typedef struct packed {
      logic [W-1:0] cnt;
   } sbc_div_state_t;

   sbc_div_state_t st_q;
   sbc_div_state_t st_d;

   // ==========================================================================
   // Counter
   // ==========================================================================
   // Wrap the count at the divide value.
   always_comb begin
      st_d = st_q;
      if (st_q.cnt == W'(DIV - 1)) begin
         st_d.cnt = '0;
      end else begin
         st_d.cnt = st_q.cnt + 1'b1;
      end
   end

   // Register the state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // The tick marks the last count; the wave is high for the lower half.
   assign tick_o = (st_q.cnt == W'(DIV - 1));
   assign clk_o  = (st_q.cnt < W'(DIV / 2));

endmodule : sbc_clk_div

`default_nettype wire

// ---- sbc_baud_select.sv ----
// Baud clock generation and status routing for two serial ports.
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Both port B clock inputs come from the zero-count output of timer channel 1.
// - Printer busy, inverted, drives the port B ring status input.
// - Floppy drive ready drives the port B carrier status input.
// - In high-speed mode port A takes a fixed 615.385 kHz clock instead of the timer.
// - Speed select at 1 picks the timer clock for port A, at 0 the fixed clock.
// - In low-speed mode port A runs from timer 0; port B always runs from timer 1.
// - Timer channels 0 and 1 are triggered from a 2.00 MHz source.
// - The timer unit runs from a 4.00 MHz master clock.
module sbc_baud_select
   import sbc_pkg::*;
(
   // Clock and reset.
   input  wire logic        CLOCK_I,
   input  wire logic        RESET_I,
   // Wishbone slave.
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // External status pins.
   input  wire logic        PRINTER_BUSY_I,
   input  wire logic        FLOPPY_READY_I,
   // Serial unit connections.
   output logic             PORT_A_SPEED_SELECT_OUT_O,
   output logic             PORT_A_BAUD_CLOCK_O,
   output logic             PORT_B_TX_CLOCK_IN_O,
   output logic             PORT_B_RX_CLOCK_IN_O,
   output logic             PORT_B_RING_STATUS_IN_O,
   output logic             PORT_B_CARRIER_STATUS_IN_O,
   // Timer zero-count outputs.
   output logic             TIMER0_ZERO_COUNT_OUT_O,
   output logic             TIMER1_ZERO_COUNT_OUT_O
);

   sbc_state_t st_q;
   sbc_state_t st_d;
   logic       trig_tick;
   logic       master_tick;
   logic       hs_clk;
   logic       hs_last;

   // ==========================================================================
   // Clock sources
   // ==========================================================================
   // Timer trigger source.
   sbc_clk_div #(.DIV(TRIG_DIV)) u_trig_div (
      .clk_i  (CLOCK_I),
      .rst_i  (RESET_I),
      .tick_o (trig_tick),
      .clk_o  ()
   );

   // Timer master clock, which paces timer mode prescaling.
   sbc_clk_div #(.DIV(MASTER_DIV)) u_master_div (
      .clk_i  (CLOCK_I),
      .rst_i  (RESET_I),
      .tick_o (master_tick),
      .clk_o  ()
   );

   // Fixed high-speed clock for port A.
   sbc_clk_div #(.DIV(HS_DIV)) u_hs_div (
      .clk_i  (CLOCK_I),
      .rst_i  (RESET_I),
      .tick_o (hs_last),
      .clk_o  (hs_clk)
   );

   // ==========================================================================
   // Next-state logic
   // ==========================================================================
   // Synchronisers, timers, clock select and the register bus.
   always_comb begin
      logic       req;
      logic       wr;
      logic [7:0] adr;
      logic [7:0] wd;
      logic [7:0] lim;
      logic       step;
      req  = 1'b0;
      wr   = 1'b0;
      adr  = 8'h00;
      wd   = 8'h00;
      lim  = 8'h00;
      step = 1'b0;
      st_d = st_q;

      // Two flip-flops on each pin before any logic looks at it.
      st_d.sync_busy  = {st_q.sync_busy[0], PRINTER_BUSY_I};
      st_d.sync_ready = {st_q.sync_ready[0], FLOPPY_READY_I};

      // Timer channels: counter mode steps on the trigger, timer mode on the prescaler.
      for (int i = 0; i < NUM_TIMERS; i++) begin
         lim = st_q.pre256[i] ? 8'(PRESCALE_HI - 1) : 8'(PRESCALE_LO - 1);
         st_d.zc[i] = 1'b0;
         if (st_q.counter_mode[i]) begin
            step = st_q.run[i] && trig_tick;
         end else begin
            step = st_q.run[i] && master_tick && (st_q.pre[i] == lim);
            if (st_q.run[i] && master_tick) begin
               st_d.pre[i] = (st_q.pre[i] == lim) ? 8'h00 : st_q.pre[i] + 8'h01;
            end
         end
         if (step) begin
            if (st_q.cnt[i] == 8'h01) begin
               st_d.zc[i]  = 1'b1;
               st_d.cnt[i] = st_q.tc[i];
            end else begin
               st_d.cnt[i] = st_q.cnt[i] - 8'h01;
            end
         end
      end

      // Switch port A only while both clocks are low now and stay low one more cycle.
      if ((st_q.speed_req != st_q.sel_low) && !st_q.zc[0] && !st_d.zc[0] && !hs_clk
          && !hs_last) begin
         st_d.sel_low = st_q.speed_req;
      end
      st_d.port_a_clk = st_q.sel_low ? st_q.zc[0] : hs_clk;

      // Bus request decode; ack follows one cycle later and a write lands with the ack.
      req      = WB_CYC_I && WB_STB_I && !st_q.ack;
      wr       = WB_CYC_I && WB_STB_I && st_q.ack && WB_WE_I && WB_SEL_I[0];
      adr      = {WB_ADR_I[7:2], 2'b00};
      wd       = WB_DAT_I[7:0];
      st_d.ack = req;

      // Register writes.
      if (wr) begin
         for (int i = 0; i < NUM_TIMERS; i++) begin
            if ((adr == (i == 0 ? OFS_T0_CTRL : OFS_T1_CTRL)) && wd[CW_CTRL_BIT]) begin
               st_d.counter_mode[i] = wd[CW_MODE_BIT];
               st_d.pre256[i]       = wd[CW_PRE_BIT];
               if (wd[CW_RESET_BIT]) begin
                  st_d.run[i] = 1'b0;
                  st_d.pre[i] = 8'h00;
                  st_d.cnt[i] = st_q.tc[i];
               end
            end
            if (adr == (i == 0 ? OFS_T0_CONST : OFS_T1_CONST)) begin
               st_d.tc[i]  = wd;
               st_d.cnt[i] = wd;
               st_d.pre[i] = 8'h00;
               st_d.run[i] = 1'b1;
            end
         end
         if (adr == OFS_LINE_CTRL) begin
            st_d.speed_req = wd[LC_SPEED_BIT];
            if (wd[LC_SNAP_BIT]) begin
               st_d.ring_snap    = !st_q.sync_busy[1];
               st_d.carrier_snap = st_q.sync_ready[1];
            end
         end
      end

      // Read data; unmapped offsets read as zero.
      st_d.rdata = 32'h0000_0000;
      if (req && !WB_WE_I) begin
         case (adr)
            OFS_T0_CTRL, OFS_T1_CTRL: begin
               st_d.rdata[CW_MODE_BIT] = st_q.counter_mode[adr[3]];
               st_d.rdata[CW_PRE_BIT]  = st_q.pre256[adr[3]];
               st_d.rdata[CW_RUN_BIT]  = st_q.run[adr[3]];
            end
            OFS_T0_CONST, OFS_T1_CONST: begin
               st_d.rdata[7:0] = st_q.cnt[adr[3]];
            end
            OFS_LINE_CTRL: begin
               st_d.rdata[LC_SPEED_BIT] = st_q.speed_req;
            end
            OFS_LINE_STAT: begin
               st_d.rdata[LS_RING_BIT]    = st_q.ring_snap;
               st_d.rdata[LS_CARRIER_BIT] = st_q.carrier_snap;
               st_d.rdata[LS_LOWSEL_BIT]  = st_q.sel_low;
               st_d.rdata[LS_RUN0_BIT]    = st_q.run[0];
               st_d.rdata[LS_RUN1_BIT]    = st_q.run[1];
            end
            default: st_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // Register the whole state.
   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         st_q           <= '0;
         st_q.speed_req <= SPEED_REQ_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   // Bus answer and routed clocks and status lines.
   assign WB_DAT_O                   = st_q.rdata;
   assign WB_ACK_O                   = st_q.ack;
   assign PORT_A_SPEED_SELECT_OUT_O  = st_q.speed_req;
   assign PORT_A_BAUD_CLOCK_O        = st_q.port_a_clk;
   assign PORT_B_TX_CLOCK_IN_O       = st_q.zc[1];
   assign PORT_B_RX_CLOCK_IN_O       = st_q.zc[1];
   assign PORT_B_RING_STATUS_IN_O    = !st_q.sync_busy[1];
   assign PORT_B_CARRIER_STATUS_IN_O = st_q.sync_ready[1];
   assign TIMER0_ZERO_COUNT_OUT_O    = st_q.zc[0];
   assign TIMER1_ZERO_COUNT_OUT_O    = st_q.zc[1];

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);

   sequence s_trig_period;
      ##20 trig_tick;
   endsequence

   sequence s_master_period;
      ##10 master_tick;
   endsequence

   sequence s_hs_period;
      ##65 $rose(hs_clk);
   endsequence

   property p_port_b_clk;
      $rose(PORT_B_TX_CLOCK_IN_O) |-> PORT_B_RX_CLOCK_IN_O && (st_q.cnt[1] == st_q.tc[1]);
   endproperty
   a_port_b_clk: assert property (p_port_b_clk) else $error("Port B clocks not from timer 1.");

   property p_ring;
      (!$past(RESET_I) && !$past(RESET_I, 2)) |->
         (PORT_B_RING_STATUS_IN_O == !$past(PRINTER_BUSY_I, 2));
   endproperty
   a_ring: assert property (p_ring) else $error("Ring status is not inverted busy.");

   property p_carrier;
      (!$past(RESET_I) && !$past(RESET_I, 2)) |->
         (PORT_B_CARRIER_STATUS_IN_O == $past(FLOPPY_READY_I, 2));
   endproperty
   a_carrier: assert property (p_carrier) else $error("Carrier status is not drive ready.");

   property p_high_speed;
      !st_q.sel_low |=> (PORT_A_BAUD_CLOCK_O == $past(hs_clk));
   endproperty
   a_high_speed: assert property (p_high_speed) else $error("Port A not on fixed clock.");

   property p_select_low;
      (PORT_A_SPEED_SELECT_OUT_O && !st_q.sel_low) |-> ##[1:70] st_q.sel_low;
   endproperty
   a_select_low: assert property (p_select_low) else $error("Low-speed select not taken.");

   property p_select_high;
      (!PORT_A_SPEED_SELECT_OUT_O && st_q.sel_low) |-> ##[1:70] !st_q.sel_low;
   endproperty
   a_select_high: assert property (p_select_high) else $error("High-speed select not taken.");

   property p_low_speed;
      st_q.sel_low |=> (PORT_A_BAUD_CLOCK_O == $past(TIMER0_ZERO_COUNT_OUT_O));
   endproperty
   a_low_speed: assert property (p_low_speed) else $error("Port A not on timer 0.");

   property p_trig_rate;
      trig_tick |-> s_trig_period;
   endproperty
   a_trig_rate: assert property (p_trig_rate) else $error("Trigger tick period wrong.");

   property p_master_rate;
      master_tick |-> s_master_period;
   endproperty
   a_master_rate: assert property (p_master_rate) else $error("Master tick period wrong.");

   property p_hs_rate;
      $rose(hs_clk) |-> s_hs_period;
   endproperty
   a_hs_rate: assert property (p_hs_rate) else $error("Fixed clock period wrong.");

   property p_glitch_free;
      $changed(st_q.sel_low) |-> !PORT_A_BAUD_CLOCK_O ##1 !PORT_A_BAUD_CLOCK_O;
   endproperty
   a_glitch_free: assert property (p_glitch_free) else $error("Clock switch not clean.");

endmodule : sbc_baud_select

`default_nettype wire

// ---- sbc_serial_model.sv ----
// Model of the dual serial unit that takes the port B clocks from the block.
`timescale 1ns/1ps
`default_nettype none

module sbc_serial_model (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Port B clock inputs of the serial unit.
   input  wire logic        b_tx_clk_i,
   input  wire logic        b_rx_clk_i,
   // Observations for the bench.
   output logic      [15:0] b_edges_o,
   output logic             b_split_o
);
   logic b_prev_q;

   // Counts rising edges of the port B transmit clock and flags any cycle where the two clock pins disagree.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         b_prev_q  <= 1'b0;
         b_edges_o <= 16'h0000;
         b_split_o <= 1'b0;
      end else begin
         b_prev_q <= b_tx_clk_i;
         if (b_tx_clk_i && !b_prev_q) begin
            b_edges_o <= b_edges_o + 16'h0001;
         end
         if (b_tx_clk_i !== b_rx_clk_i) begin
            b_split_o <= 1'b1;
         end
      end
   end
endmodule : sbc_serial_model

`default_nettype wire

// ---- test_serial_baud_clock_select.sv ----
// Self-checking bench for the serial baud clock select block.
`timescale 1ns/1ps
`default_nettype none

module test_serial_baud_clock_select;
   import sbc_pkg::*;

   // =========================================================================
   // Signals
   // =========================================================================
   logic        CLOCK_I, RESET_I, WB_CYC_I, WB_STB_I, WB_WE_I;
   logic [7:0]  WB_ADR_I;
   logic [3:0]  WB_SEL_I;
   logic [31:0] WB_DAT_I, WB_DAT_O, d;
   logic        WB_ACK_O, PRINTER_BUSY_I, FLOPPY_READY_I, spd, aclk, btx, brx;
   logic        ring, carrier, t0zc, t1zc, b_split, cm, pr;
   logic [15:0] b_edges, lfsr_q;
   logic [7:0]  tc;
   logic [7:0]  tcs [7] = '{8'h0d, 8'h34, 8'hd0, 8'h01, 8'h02, 8'h01, 8'h00};
   int          bad_count, total_checks, cyc_count, n;

   sbc_baud_select dut_u (
      .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
      .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
      .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PRINTER_BUSY_I(PRINTER_BUSY_I),
      .FLOPPY_READY_I(FLOPPY_READY_I), .PORT_A_SPEED_SELECT_OUT_O(spd),
      .PORT_A_BAUD_CLOCK_O(aclk), .PORT_B_TX_CLOCK_IN_O(btx), .PORT_B_RX_CLOCK_IN_O(brx),
      .PORT_B_RING_STATUS_IN_O(ring), .PORT_B_CARRIER_STATUS_IN_O(carrier),
      .TIMER0_ZERO_COUNT_OUT_O(t0zc), .TIMER1_ZERO_COUNT_OUT_O(t1zc));

   sbc_serial_model far_u (
      .clk_i(CLOCK_I), .rst_i(RESET_I), .b_tx_clk_i(btx), .b_rx_clk_i(brx),
      .b_edges_o(b_edges), .b_split_o(b_split));

   // =========================================================================
   // Clock, timeout and helpers
   // =========================================================================
   // Free-running 40 MHz clock.
   always #12.5 CLOCK_I = ~CLOCK_I;

   // Cuts a hung run short.
   always @(posedge CLOCK_I) begin
      cyc_count++;
      if (cyc_count == 60000) begin
         bad_count++;
         complete_run();
      end
   end

   // Next value of the stimulus shift register.
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   // Expected cycles between zero-count pulses for one timer setting.
   function automatic int exp_period(input logic c, input logic p, input logic [7:0] t);
      int steps;
      steps = (t == 8'h00) ? 256 : int'(t);
      if (c) return steps * TRIG_DIV;
      return steps * (p ? PRESCALE_HI : PRESCALE_LO) * MASTER_DIV;
   endfunction : exp_period

   // Picks one of the watched clock outputs.
   function automatic logic pick(input int s);
      if (s == 0) return aclk;
      if (s == 1) return t1zc;
      return t0zc;
   endfunction : pick

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One classic Wishbone cycle; only the run's timeout ends the wait for ack.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel, output logic [31:0] rdat);
      @(posedge CLOCK_I);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I  <= we;
      WB_ADR_I <= adr;
      WB_DAT_I <= dat;
      WB_SEL_I <= sel;
      do begin
         @(posedge CLOCK_I);
      end while (WB_ACK_O !== 1'b1);
      rdat = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] adr, input logic [7:0] v);
      logic [31:0] x;
      wb(1'b1, adr, {24'h00_0000, v}, 4'h1, x);
   endtask : wr

   task automatic rd(input logic [7:0] adr, output logic [31:0] v);
      wb(1'b0, adr, 32'h0000_0000, 4'hf, v);
   endtask : rd

   // Programs one timer channel: control word, then constant.
   task automatic prog(input int ch, input logic c, input logic p, input logic [7:0] t);
      wr(ch ? OFS_T1_CTRL : OFS_T0_CTRL, {1'b0, c, p, 4'h0, 1'b1});
      wr(ch ? OFS_T1_CONST : OFS_T0_CONST, t);
   endtask : prog

   // Waits for a low then a high level, counting cycles in k.
   task automatic wait_rise(input int s, inout int k);
      while (pick(s) !== 1'b0 && k < 9000) begin
         @(posedge CLOCK_I);
         #1 k++;
      end
      while (pick(s) !== 1'b1 && k < 9000) begin
         @(posedge CLOCK_I);
         #1 k++;
      end
   endtask : wait_rise

   task automatic period(input int s, output int k);
      k = 0;
      wait_rise(s, k);
      k = 0;
      wait_rise(s, k);
   endtask : period

   task automatic complete_run();
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   // =========================================================================
   // Main sequence
   // =========================================================================
   initial begin
      {CLOCK_I, WB_CYC_I, WB_STB_I, WB_WE_I, PRINTER_BUSY_I, FLOPPY_READY_I} = '0;
      {WB_ADR_I, WB_SEL_I, WB_DAT_I} = '0;
      {bad_count, total_checks, cyc_count} = '0;
      RESET_I = 1'b1;
      lfsr_q = 16'd35732;
      repeat (8) @(posedge CLOCK_I);
      RESET_I <= 1'b0;
      #1;
      chk(spd, 0);
      chk(ring, 1);
      // Fixed clock on port A after reset.
      period(0, n);
      chk(n, HS_DIV);
      // Status pins with random levels, then a snapshot through the status register.
      repeat (8) begin
         lfsr_q = lfsr(lfsr_q);
         @(posedge CLOCK_I);
         PRINTER_BUSY_I <= lfsr_q[0];
         FLOPPY_READY_I <= lfsr_q[1];
         repeat (3) @(posedge CLOCK_I);
         #1;
         chk(ring, !lfsr_q[0]);
         chk(carrier, lfsr_q[1]);
         wr(OFS_LINE_CTRL, 8'h02);
         rd(OFS_LINE_STAT, d);
         chk(d & 32'h0000_0003, {30'h0, lfsr_q[1], !lfsr_q[0]});
      end
      // Port B timer settings, standard, nonstandard and one random constant.
      for (int i = 0; i < 7; i++) begin
         lfsr_q = lfsr(lfsr_q);
         cm = (i < 4) || (i == 6);
         pr = (i == 5);
         tc = (i == 6) ? ({4'h0, lfsr_q[3:0]} | 8'h01) : tcs[i];
         prog(1, cm, pr, tc);
         period(1, n);
         chk(n, exp_period(cm, pr, tc));
         period(1, n);
         chk(n, exp_period(cm, pr, tc));
         rd(OFS_T1_CTRL, d);
         chk(d & 32'h0000_00e0, {24'h00_0000, 1'b1, cm, pr, 5'h00});
      end
      // Low-speed path for port A from timer 0.
      prog(0, 1'b1, 1'b0, 8'h03);
      wr(OFS_LINE_CTRL, 8'h01);
      repeat (80) @(posedge CLOCK_I);
      #1;
      chk(spd, 1);
      period(0, n);
      chk(n, exp_period(1'b1, 1'b0, 8'h03));
      rd(OFS_LINE_STAT, d);
      chk(d & 32'h0000_0004, 32'h0000_0004);
      // High-speed entry: stop timer 0, then clear speed select.
      wr(OFS_T0_CTRL, 8'h03);
      rd(OFS_T0_CTRL, d);
      chk(d & 32'h0000_0080, 0);
      wr(OFS_LINE_CTRL, 8'h00);
      n = 0;
      repeat (300) begin
         @(posedge CLOCK_I);
         #1 n += t0zc;
      end
      chk(n, 0);
      period(0, n);
      chk(n, HS_DIV);
      rd(OFS_LINE_STAT, d);
      chk(d & 32'h0000_0004, 0);
      // Ignored writes and an unmapped address.
      wb(1'b1, OFS_LINE_CTRL, 32'h0000_0001, 4'h0, d);
      rd(OFS_LINE_CTRL, d);
      chk(d & 32'h0000_0001, 0);
      wb(1'b1, 8'h18, 32'h0000_00ff, 4'hf, d);
      rd(8'h18, d);
      chk(d, 0);
      chk(b_split, 0);
      chk(b_edges != 16'h0000, 1);
      complete_run();
   end
endmodule : test_serial_baud_clock_select

`default_nettype wire
